// ==== rtl/rcl_pkg.sv ====
// constants and types shared by the reclocker rate, lock and alarm control block
package rcl_pkg;

   // register offsets
   localparam logic [7:0] RCL_OFS_PULSE_WIDTH = 8'h0E;
   localparam logic [7:0] RCL_OFS_RATE_MODE = 8'h12;
   localparam logic [7:0] RCL_OFS_BYPASS = 8'h14;
   localparam logic [7:0] RCL_OFS_LOOP_BW = 8'h16;
   localparam logic [7:0] RCL_OFS_RATE_IND = 8'h18;
   localparam logic [7:0] RCL_OFS_ALARM_CLEAR = 8'h85;
   localparam logic [7:0] RCL_OFS_ALARM_STATUS = 8'h88;
   localparam logic [7:0] RCL_OFS_DETECTED_RATE = 8'h89;

   // values after reset
   localparam logic [7:0] RCL_RST_PULSE_WIDTH = 8'h00;
   localparam logic [7:0] RCL_RST_RATE_MODE = 8'h00;
   localparam logic [7:0] RCL_RST_BYPASS = 8'h00;
   localparam logic [7:0] RCL_RST_LOOP_BW = 8'h20;
   localparam logic [7:0] RCL_RST_RATE_IND = 8'hC8;
   localparam logic [7:0] RCL_RST_ALARM_CLEAR = 8'h00;

   // field positions
   localparam int RCL_BIT_PDOWN = 0;
   localparam int RCL_BIT_FORCE_BYPASS = 1;
   localparam int RCL_LSB_RATE_MODE = 2;
   localparam int RCL_BIT_AUTO_BYPASS_DIS = 0;
   localparam int RCL_LSB_LOOP_BW = 4;
   localparam int RCL_BIT_UNLOCKED_POLICY = 5;
   localparam int RCL_BIT_ALARM_CLEAR = 0;
   localparam int RCL_LSB_PULSE_WIDTH = 0;
   localparam int RCL_BIT_DATA_UNLOCK = 0;
   localparam int RCL_BIT_SIGNAL_LOSS = 1;
   localparam int RCL_BIT_REF_MISSING = 2;
   localparam int RCL_BIT_REF_UNLOCK = 4;

   // rate codes, shared by detector result and manual selection
   typedef enum logic [1:0] {
      RCL_RATE_NONE = 2'h0,
      RCL_RATE_SD = 2'h1,
      RCL_RATE_HD = 2'h2,
      RCL_RATE_3G = 2'h3
   } rcl_rate_e;

   // control mode of the device
   typedef enum logic [1:0] {
      RCL_MODE_PIN_STRAP = 2'h0,
      RCL_MODE_FOUR_WIRE = 2'h1,
      RCL_MODE_TWO_WIRE = 2'h2
   } rcl_ctl_mode_e;

   // alarm pulse timing
   localparam int RCL_CLK_PERIOD_PS = 4000;
   localparam int RCL_PULSE_MIN_NS = 20;
   localparam int RCL_PULSE_MAX_NS = 2560;
   localparam int RCL_PULSE_STEPS = 15;
   localparam logic [9:0] RCL_PULSE_MIN_CYC =
      10'((RCL_PULSE_MIN_NS * 1000 + RCL_CLK_PERIOD_PS - 1) / RCL_CLK_PERIOD_PS);
   localparam logic [9:0] RCL_PULSE_MAX_CYC =
      10'((RCL_PULSE_MAX_NS * 1000) / RCL_CLK_PERIOD_PS);

   localparam int RCL_PULSE_CNT_W = 10;

endpackage

// ==== rtl/rcl_alarm_pulse.sv ====
// one-shot timer that holds the alarm pin low for a programmed width
`timescale 1ns/1ps
module rcl_alarm_pulse (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic trigger,
   input wire logic [3:0] width_sel,
   output logic pulse_active
);
   import rcl_pkg::*;

   typedef enum logic [1:0] {
      RCL_PS_IDLE = 2'b01,
      RCL_PS_LOW = 2'b10
   } rcl_pulse_state_e;

   typedef struct packed {
      rcl_pulse_state_e st;
      logic [RCL_PULSE_CNT_W-1:0] cnt;
      logic active;
   } rcl_pulse_s;

   rcl_pulse_s s_r;
   rcl_pulse_s s_nxt;
   logic [RCL_PULSE_CNT_W-1:0] width_cyc;

   // linear steps between the two end points, both hit exactly
   always_comb begin
      width_cyc = RCL_PULSE_MIN_CYC + RCL_PULSE_CNT_W'(
         (32'(width_sel) * 32'(RCL_PULSE_MAX_CYC - RCL_PULSE_MIN_CYC)) / RCL_PULSE_STEPS);
   end

   always_comb begin
      s_nxt = s_r;
      case (s_r.st)
         RCL_PS_IDLE: begin
            if (trigger) begin
               s_nxt.st = RCL_PS_LOW;
               s_nxt.cnt = width_cyc - RCL_PULSE_CNT_W'(1);
               s_nxt.active = 1'b1;
            end
         end
         RCL_PS_LOW: begin
            // a fresh alarm restarts the full width
            if (trigger) begin
               s_nxt.cnt = width_cyc - RCL_PULSE_CNT_W'(1);
            end else if (s_r.cnt == '0) begin
               s_nxt.st = RCL_PS_IDLE;
               s_nxt.active = 1'b0;
            end else begin
               s_nxt.cnt = s_r.cnt - RCL_PULSE_CNT_W'(1);
            end
         end
         default: begin
            s_nxt.st = RCL_PS_IDLE;
            s_nxt.cnt = '0;
            s_nxt.active = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_r.st <= RCL_PS_IDLE;
         s_r.cnt <= '0;
         s_r.active <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pulse_active = s_r.active;

endmodule // rcl_alarm_pulse

// ==== rtl/rcl_ctrl.sv ====
// register file, rate selection, lock flags and alarm pin control of the reclocker
`timescale 1ns/1ps

module rcl_ctrl (
   input wire logic core_clk,
   input wire logic sys_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // monitors from the analog side
   input wire logic ref_clk_present,
   input wire logic ref_pll_locked,
   input wire logic freq_in_window,
   input wire logic signal_loss_in,
   input wire rcl_pkg::rcl_rate_e auto_rate_detector,
   input wire rcl_pkg::rcl_ctl_mode_e control_mode,
   // controls to the analog side
   output rcl_pkg::rcl_rate_e rate_sel,
   output logic rate_auto,
   output logic bypass_en,
   output logic power_down,
   output logic [2:0] loop_bandwidth_sel,
   // pins
   output logic sd_rate_indicator_pin,
   output logic alarm_pulse_pin_o,
   output logic alarm_pulse_pin_oe
);
   import rcl_pkg::*;

   typedef struct packed {
      logic [7:0] pulse_width;
      logic [7:0] rate_mode;
      logic [7:0] bypass_ctl;
      logic [7:0] loop_bw;
      logic [7:0] rate_ind;
      logic [7:0] alarm_clear;
      logic data_unlock_lat;
      logic signal_loss_lat;
      logic [3:0] alarm_prev;
      logic alarm_trig;
      logic [7:0] rdata;
      logic rvalid;
      rcl_rate_e rate_sel;
      logic rate_auto;
      logic bypass;
      logic pdown;
      logic [2:0] bw_sel;
      logic sd_pin;
      logic alarm_oe;
   } rcl_ctrl_s;

   rcl_ctrl_s s_r;
   rcl_ctrl_s s_nxt;

   logic pulse_active;
   logic serial_mode;
   logic data_unlock_raw;
   logic ref_missing_raw;
   logic ref_unlock_raw;
   logic [3:0] alarm_now;
   logic [1:0] mode_field;
   logic manual;
   rcl_rate_e manual_rate;
   logic harmonic_ok;
   logic locked;
   rcl_rate_e locked_rate;
   logic [7:0] status_byte;
   logic [7:0] rate_byte;
   logic clear_held;

   rcl_alarm_pulse u_pulse (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .trigger(s_r.alarm_trig),
      .width_sel(s_r.pulse_width[RCL_LSB_PULSE_WIDTH +: 4]),
      .pulse_active(pulse_active)
   );

   // decode of the present conditions
   always_comb begin
      ref_missing_raw = ~ref_clk_present;
      ref_unlock_raw = ~ref_pll_locked;
      data_unlock_raw = ~freq_in_window;
      mode_field = s_r.rate_mode[RCL_LSB_RATE_MODE +: 2];
      manual = (mode_field != 2'h0);
      manual_rate = rcl_rate_e'(mode_field);
      // a forced HD rate also accepts the next harmonic, 3G; SD and 3G accept only their own rate
      harmonic_ok = (auto_rate_detector == manual_rate) ||
                    ((manual_rate == RCL_RATE_HD) && (auto_rate_detector == RCL_RATE_3G));
      if (manual) begin
         locked = freq_in_window && harmonic_ok;
      end else begin
         locked = freq_in_window && (auto_rate_detector != RCL_RATE_NONE);
      end
      if (!locked) begin
         locked_rate = RCL_RATE_NONE;
      end else if (manual) begin
         locked_rate = auto_rate_detector;
      end else begin
         locked_rate = auto_rate_detector;
      end
      clear_held = s_r.alarm_clear[RCL_BIT_ALARM_CLEAR];
      serial_mode = (control_mode == RCL_MODE_FOUR_WIRE) ||
                    (control_mode == RCL_MODE_TWO_WIRE);
      alarm_now = {ref_unlock_raw, ref_missing_raw, data_unlock_raw, signal_loss_in};
   end

   // read views
   always_comb begin
      status_byte = 8'h00;
      status_byte[RCL_BIT_DATA_UNLOCK] = s_r.data_unlock_lat;
      status_byte[RCL_BIT_SIGNAL_LOSS] = s_r.signal_loss_lat;
      status_byte[RCL_BIT_REF_MISSING] = ref_missing_raw;
      status_byte[RCL_BIT_REF_UNLOCK] = ref_unlock_raw;
      rate_byte = {6'h00, locked_rate};
   end

   always_comb begin
      s_nxt = s_r;

      // register writes
      if (reg_wr) begin
         case (reg_addr)
            RCL_OFS_PULSE_WIDTH: s_nxt.pulse_width = reg_wdata;
            RCL_OFS_RATE_MODE: s_nxt.rate_mode = reg_wdata;
            RCL_OFS_BYPASS: s_nxt.bypass_ctl = reg_wdata;
            RCL_OFS_LOOP_BW: s_nxt.loop_bw = reg_wdata;
            RCL_OFS_RATE_IND: s_nxt.rate_ind = reg_wdata;
            RCL_OFS_ALARM_CLEAR: s_nxt.alarm_clear = reg_wdata;
            default: begin
            end
         endcase
      end

      // register reads, answered one cycle later
      s_nxt.rvalid = reg_rd;
      if (reg_rd) begin
         case (reg_addr)
            RCL_OFS_PULSE_WIDTH: s_nxt.rdata = s_r.pulse_width;
            RCL_OFS_RATE_MODE: s_nxt.rdata = s_r.rate_mode;
            RCL_OFS_BYPASS: s_nxt.rdata = s_r.bypass_ctl;
            RCL_OFS_LOOP_BW: s_nxt.rdata = s_r.loop_bw;
            RCL_OFS_RATE_IND: s_nxt.rdata = s_r.rate_ind;
            RCL_OFS_ALARM_CLEAR: s_nxt.rdata = s_r.alarm_clear;
            RCL_OFS_ALARM_STATUS: s_nxt.rdata = status_byte;
            RCL_OFS_DETECTED_RATE: s_nxt.rdata = rate_byte;
            default: s_nxt.rdata = 8'h00;
         endcase
      end

      // latched flags: the clear level dominates, so latching is frozen
      // for as long as software leaves the clear bit set
      if (clear_held) begin
         s_nxt.data_unlock_lat = 1'b0;
         s_nxt.signal_loss_lat = 1'b0;
      end else begin
         s_nxt.data_unlock_lat = s_r.data_unlock_lat | data_unlock_raw;
         s_nxt.signal_loss_lat = s_r.signal_loss_lat | signal_loss_in;
      end

      // any newly asserted alarm fires the pulse, unless the pins strap the device
      s_nxt.alarm_prev = alarm_now;
      s_nxt.alarm_trig = serial_mode && ((alarm_now & ~s_r.alarm_prev) != 4'h0);
      s_nxt.alarm_oe = serial_mode && pulse_active;

      // reclocker controls
      s_nxt.rate_auto = ~manual;
      s_nxt.rate_sel = manual ? manual_rate : auto_rate_detector;
      s_nxt.pdown = s_r.rate_mode[RCL_BIT_PDOWN];
      // unidentified rate passes the data through untimed
      s_nxt.bypass = s_r.rate_mode[RCL_BIT_FORCE_BYPASS] ||
                     (~s_r.bypass_ctl[RCL_BIT_AUTO_BYPASS_DIS] && ~manual &&
                      (auto_rate_detector == RCL_RATE_NONE));
      // no clamp above 2x: software owns the jitter trade-off
      s_nxt.bw_sel = s_r.loop_bw[RCL_LSB_LOOP_BW +: 3];

      // rate indicator: 3G reports as HD so the cable driver keeps fast edges
      if (locked) begin
         s_nxt.sd_pin = (locked_rate == RCL_RATE_SD);
      end else begin
         s_nxt.sd_pin = s_r.rate_ind[RCL_BIT_UNLOCKED_POLICY];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_r.pulse_width <= RCL_RST_PULSE_WIDTH;
         s_r.rate_mode <= RCL_RST_RATE_MODE;
         s_r.bypass_ctl <= RCL_RST_BYPASS;
         s_r.loop_bw <= RCL_RST_LOOP_BW;
         s_r.rate_ind <= RCL_RST_RATE_IND;
         s_r.alarm_clear <= RCL_RST_ALARM_CLEAR;
         s_r.data_unlock_lat <= 1'b0;
         s_r.signal_loss_lat <= 1'b0;
         s_r.alarm_prev <= 4'h0;
         s_r.alarm_trig <= 1'b0;
         s_r.rdata <= 8'h00;
         s_r.rvalid <= 1'b0;
         s_r.rate_sel <= RCL_RATE_NONE;
         s_r.rate_auto <= 1'b1;
         s_r.bypass <= 1'b0;
         s_r.pdown <= 1'b0;
         s_r.bw_sel <= RCL_RST_LOOP_BW[RCL_LSB_LOOP_BW +: 3];
         s_r.sd_pin <= 1'b0;
         s_r.alarm_oe <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign reg_rvalid = s_r.rvalid;
   assign rate_sel = s_r.rate_sel;
   assign rate_auto = s_r.rate_auto;
   assign bypass_en = s_r.bypass;
   assign power_down = s_r.pdown;
   assign loop_bandwidth_sel = s_r.bw_sel;
   assign sd_rate_indicator_pin = s_r.sd_pin;
   // open drain: only ever pulls low; the released level comes from the pull-up
   assign alarm_pulse_pin_o = 1'b0;
   assign alarm_pulse_pin_oe = s_r.alarm_oe;

endmodule // rcl_ctrl

// ==== dv/rcl_ctrl_checker.sv ====
// port-level assertions for the reclocker rate, lock and alarm control block
`timescale 1ns/1ps
module rcl_ctrl_checker (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic ref_clk_present,
   input wire logic signal_loss_in,
   input wire rcl_pkg::rcl_ctl_mode_e control_mode,
   input wire logic rate_auto,
   input wire logic bypass_en,
   input wire logic [2:0] loop_bandwidth_sel,
   input wire logic alarm_pulse_pin_oe
);
   import rcl_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // stable input only: the live flag is decoded from the pin with no register in between
   chk_ref_missing: assert property (
      reg_rd && reg_addr == RCL_OFS_ALARM_STATUS && $stable(ref_clk_present)
      |=> reg_rvalid && reg_rdata[RCL_BIT_REF_MISSING] == !$past(ref_clk_present))
      else $error("ref missing flag wrong");
   chk_status_spare: assert property (
      reg_rd && reg_addr == RCL_OFS_ALARM_STATUS |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[3])
      else $error("spare status bits set");
   chk_rate_mode: assert property (
      reg_wr && reg_addr == RCL_OFS_RATE_MODE
      |-> ##2 rate_auto == ($past(reg_wdata[3:2], 2) == 2'h0))
      else $error("rate mode not applied");
   chk_force_bypass: assert property (
      reg_wr && reg_addr == RCL_OFS_RATE_MODE && reg_wdata[1] |-> ##2 bypass_en)
      else $error("forced bypass missing");
   chk_bw_field: assert property (
      reg_wr && reg_addr == RCL_OFS_LOOP_BW |-> ##2 loop_bandwidth_sel == $past(reg_wdata[6:4], 2))
      else $error("bandwidth field wrong");
   chk_pin_strap: assert property (
      (control_mode == RCL_MODE_PIN_STRAP) [*3] |-> !alarm_pulse_pin_oe)
      else $error("alarm pin active in pin-strap mode");
   chk_pulse_start: assert property (
      $rose(signal_loss_in) && control_mode == RCL_MODE_FOUR_WIRE |-> ##3 alarm_pulse_pin_oe)
      else $error("alarm pulse did not start");
   chk_pulse_min: assert property (
      $rose(alarm_pulse_pin_oe) |-> alarm_pulse_pin_oe [*5])
      else $error("alarm pulse too short");
   cover property ($rose(alarm_pulse_pin_oe));
   cover property ($rose(bypass_en));
   cover property (reg_rd && reg_addr == RCL_OFS_ALARM_STATUS);
endmodule // rcl_ctrl_checker

bind rcl_ctrl rcl_ctrl_checker u_chk (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .reg_rvalid, .ref_clk_present, .signal_loss_in, .control_mode,
   .rate_auto, .bypass_en, .loop_bandwidth_sel, .alarm_pulse_pin_oe);

// ==== dv/rcl_host_model.sv ====
// host processor model: register strobes and alarm pin watcher
`timescale 1ns/1ps
module rcl_host_model (
   input wire logic core_clk,
   input wire logic alarm_level,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   int pulses = 0;
   int width = 0;
   int run = 0;
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // low time is counted in sampled cycles so it compares with the timer directly
   always @(posedge core_clk) begin
      if (!alarm_level) begin
         run <= run + 1;
      end else if (run != 0) begin
         pulses <= pulses + 1;
         width <= run;
         run <= 0;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      d = reg_rvalid ? reg_rdata : 8'hXX;
   endtask
   task automatic clr;
      wr(8'h85, 8'h01);
      wr(8'h85, 8'h00);
   endtask
endmodule // rcl_host_model

// ==== dv/rcl_ctrl_tb.sv ====
// self-checking bench for the reclocker rate, lock and alarm control block
`timescale 1ns/1ps
module rcl_ctrl_tb;
   import rcl_pkg::*;
   logic core_clk, sys_rst, reg_wr, reg_rd, reg_rvalid, rate_auto, bypass_en, power_down;
   logic ref_clk_present, ref_pll_locked, freq_in_window, signal_loss_in;
   logic sd_rate_indicator_pin, alarm_pulse_pin_o, alarm_pulse_pin_oe;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   logic [2:0] loop_bandwidth_sel;
   rcl_rate_e auto_rate_detector, rate_sel;
   rcl_ctl_mode_e control_mode;
   int n_fail = 0;
   int num_checks = 0;
   // pull-up keeps the open-drain pin high when released
   wire alarm_level = alarm_pulse_pin_oe ? alarm_pulse_pin_o : 1'b1;
   rcl_ctrl u_dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .reg_rvalid, .ref_clk_present, .ref_pll_locked, .freq_in_window, .signal_loss_in,
      .auto_rate_detector, .control_mode, .rate_sel, .rate_auto, .bypass_en, .power_down,
      .loop_bandwidth_sel, .sd_rate_indicator_pin, .alarm_pulse_pin_o, .alarm_pulse_pin_oe);
   rcl_host_model u_host (.core_clk, .alarm_level, .reg_rdata, .reg_rvalid, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      u_host.rd(a, v);
      check(v, exp);
   endtask
   task automatic settle;
      repeat (4) @(negedge core_clk);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic test_regs;
      logic [7:0] ofs [6];
      logic [7:0] rst [6];
      ofs = '{RCL_OFS_PULSE_WIDTH, RCL_OFS_RATE_MODE, RCL_OFS_BYPASS, RCL_OFS_LOOP_BW,
         RCL_OFS_RATE_IND, RCL_OFS_ALARM_CLEAR};
      rst = '{RCL_RST_PULSE_WIDTH, RCL_RST_RATE_MODE, RCL_RST_BYPASS, RCL_RST_LOOP_BW,
         RCL_RST_RATE_IND, RCL_RST_ALARM_CLEAR};
      for (int i = 0; i < 6; i++) rdchk(ofs[i], rst[i]);
      u_host.wr(RCL_OFS_LOOP_BW, 8'h70);
      settle();
      check(loop_bandwidth_sel, 3'h7);
      rdchk(RCL_OFS_LOOP_BW, 8'h70);
      u_host.wr(RCL_OFS_DETECTED_RATE, 8'hFF);
      rdchk(RCL_OFS_DETECTED_RATE, 8'h01);
      rdchk(8'h40, 8'h00);
      u_host.wr(RCL_OFS_LOOP_BW, RCL_RST_LOOP_BW);
      $display("test_regs done");
   endtask
   task automatic test_flags;
      ref_clk_present = 1'b0;
      settle();
      rdchk(RCL_OFS_ALARM_STATUS, 8'h04);
      ref_clk_present = 1'b1;
      ref_pll_locked = 1'b0;
      settle();
      rdchk(RCL_OFS_ALARM_STATUS, 8'h10);
      ref_pll_locked = 1'b1;
      freq_in_window = 1'b0;
      settle();
      freq_in_window = 1'b1;
      signal_loss_in = 1'b1;
      settle();
      signal_loss_in = 1'b0;
      settle();
      rdchk(RCL_OFS_ALARM_STATUS, 8'h03);
      u_host.clr();
      rdchk(RCL_OFS_ALARM_STATUS, 8'h00);
      u_host.wr(RCL_OFS_ALARM_CLEAR, 8'h01);
      signal_loss_in = 1'b1;
      settle();
      signal_loss_in = 1'b0;
      rdchk(RCL_OFS_ALARM_STATUS, 8'h00);
      u_host.wr(RCL_OFS_ALARM_CLEAR, 8'h00);
      $display("test_flags done");
   endtask
   task automatic test_rate;
      for (int r = 1; r < 4; r++) begin
         auto_rate_detector = rcl_rate_e'(r);
         settle();
         rdchk(RCL_OFS_DETECTED_RATE, 8'(r));
         check(sd_rate_indicator_pin, r == 1);
      end
      auto_rate_detector = RCL_RATE_NONE;
      settle();
      rdchk(RCL_OFS_DETECTED_RATE, 8'h00);
      check({bypass_en, sd_rate_indicator_pin}, 2'b10);
      u_host.wr(RCL_OFS_RATE_IND, 8'hE8);
      u_host.wr(RCL_OFS_BYPASS, 8'h01);
      settle();
      check({bypass_en, sd_rate_indicator_pin}, 2'b01);
      for (int m = 1; m < 4; m++) begin
         u_host.wr(RCL_OFS_RATE_MODE, 8'(m << 2));
         auto_rate_detector = rcl_rate_e'(m);
         settle();
         rdchk(RCL_OFS_DETECTED_RATE, 8'(m));
         check({rate_auto, rate_sel}, {1'b0, 2'(m)});
      end
      u_host.wr(RCL_OFS_RATE_MODE, 8'h08);
      settle();
      rdchk(RCL_OFS_DETECTED_RATE, 8'h03);
      check(sd_rate_indicator_pin, 1'b0);
      auto_rate_detector = RCL_RATE_SD;
      settle();
      rdchk(RCL_OFS_DETECTED_RATE, 8'h00);
      u_host.wr(RCL_OFS_RATE_MODE, 8'h03);
      settle();
      check({power_down, bypass_en}, 2'b11);
      u_host.wr(RCL_OFS_RATE_MODE, 8'h00);
      u_host.wr(RCL_OFS_BYPASS, 8'h00);
      u_host.wr(RCL_OFS_RATE_IND, RCL_RST_RATE_IND);
      settle();
      u_host.clr();
      $display("test_rate done");
   endtask
   // a mid-run reset must drop power_down, bypass_en, rate_auto and loop_bandwidth_sel back to their idle values
   task automatic test_reset;
      u_host.wr(RCL_OFS_RATE_MODE, 8'h03);
      u_host.wr(RCL_OFS_LOOP_BW, 8'h70);
      settle();
      sys_rst = 1'b1;
      repeat (4) @(negedge core_clk);
      sys_rst = 1'b0;
      @(negedge core_clk);
      check({power_down, bypass_en, rate_auto}, 3'b001);
      check(loop_bandwidth_sel, RCL_RST_LOOP_BW[RCL_LSB_LOOP_BW +: 3]);
      rdchk(RCL_OFS_RATE_MODE, RCL_RST_RATE_MODE);
      rdchk(RCL_OFS_LOOP_BW, RCL_RST_LOOP_BW);
      $display("test_reset done");
   endtask
   task automatic test_alarm;
      int p;
      int w;
      for (int s = 0; s < 16; s += 15) begin
         w = RCL_PULSE_MIN_CYC + s * (RCL_PULSE_MAX_CYC - RCL_PULSE_MIN_CYC) / RCL_PULSE_STEPS;
         u_host.wr(RCL_OFS_PULSE_WIDTH, 8'(s));
         p = u_host.pulses;
         signal_loss_in = 1'b1;
         repeat (w + 10) @(negedge core_clk);
         check(u_host.pulses, p + 1);
         check(u_host.width, w);
         signal_loss_in = 1'b0;
         rdchk(RCL_OFS_ALARM_STATUS, 8'h02);
         u_host.clr();
      end
      u_host.wr(RCL_OFS_PULSE_WIDTH, 8'h00);
      for (int k = 0; k < 4; k++) begin
         p = u_host.pulses;
         {signal_loss_in, freq_in_window, ref_clk_present, ref_pll_locked} = 4'h7 ^ (4'h8 >> k);
         repeat (14) @(negedge core_clk);
         check(u_host.pulses, p + 1);
         {signal_loss_in, freq_in_window, ref_clk_present, ref_pll_locked} = 4'h7;
         settle();
         u_host.clr();
      end
      for (int c = 0; c < 3; c++) begin
         control_mode = rcl_ctl_mode_e'(c);
         p = u_host.pulses;
         settle();
         signal_loss_in = 1'b1;
         repeat (14) @(negedge core_clk);
         check(u_host.pulses, p + (c != 0));
         signal_loss_in = 1'b0;
         u_host.clr();
      end
      $display("test_alarm done");
   endtask
   initial begin
      #200us;
      n_fail++;
      give_verdict();
   end
   initial begin
      sys_rst = 1'b1;
      {signal_loss_in, freq_in_window, ref_clk_present, ref_pll_locked} = 4'h7;
      auto_rate_detector = RCL_RATE_SD;
      control_mode = RCL_MODE_FOUR_WIRE;
      repeat (4) @(negedge core_clk);
      sys_rst = 1'b0;
      test_regs();
      test_flags();
      test_rate();
      test_reset();
      test_alarm();
      give_verdict();
   end
endmodule // rcl_ctrl_tb
